//--- rtl/mie_alu.sv
// Eight-bit arithmetic and logic unit of the execute core.
// Purely combinational; the core decides which results and flags to keep.
`timescale 1ns/100ps
module mie_alu
  import mie_pkg::*;
(
  // Operation and operands
  input wire mie_alu_func_type func,
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  input wire logic carry_in,
  // Results
  output logic [7:0] result,
  output logic zero_out,
  output logic carry_out
);

  logic [8:0] wide;

  // ==========================================================================
  // Operation select
  // ==========================================================================
  // Computes the result with carry-out or borrow in the ninth bit.
  always_comb begin
    wide = {carry_in, op_a};
    unique case (func)
      ALU_ADD: wide = {1'b0, op_a} + {1'b0, op_b}; // RL22
      ALU_AND: wide = {1'b0, op_a & op_b};
      ALU_CP, ALU_SUB: wide = {1'b0, op_a} - {1'b0, op_b}; // RL22
      ALU_INC: wide = {carry_in, op_a + 8'h01};
      ALU_DEC: wide = {carry_in, op_a - 8'h01};
      ALU_COM: wide = {op_a[7], ~op_a};
      ALU_RLC: wide = {op_a[7], op_a[6:0], carry_in};
      ALU_SLA: wide = {op_a[7], op_a[6:0], 1'b0};
      ALU_CLR: wide = 9'h000;
      ALU_PASS: wide = {carry_in, op_a};
    endcase
  end

  // Zero reflects the 8-bit result only.
  assign result = wide[7:0];
  assign zero_out = (wide[7:0] == 8'h00); // RL22
  assign carry_out = wide[8];

endmodule

//--- rtl/mie_core.sv
// Instruction decode and execute core of an 8-bit microcontroller.
// Assumes asynchronous-read program and data memories outside the core.
// Functional notes
// RL1: Add, and, compare, subtract use accumulator plus memory or immediate.
// RL2: Clear, decrement, increment may target any of 256 data locations.
// RL3: Complement, rotate and shift act on accumulator and update both flags.
// RL4: Arithmetic and logic take four cycles; indirect one byte, others two.
// RL5: Increment and decrement update zero only; lengths by addressing mode.
// RL6: Clearing a direct register is three bytes and keeps both flags.
// RL7: Clearing the accumulator is two bytes, four cycles, updates flags.
// RL8: Shift is two bytes, rotate one byte, both four cycles.
// RL9: Four short branches test carry or zero; one byte, two cycles.
// RL10: Short branch displacement spans -15 to +16 around its address.
// RL11: Bit-test branches on bit clear or set; three bytes, five cycles.
// RL12: Bit-test displacement is eight-bit signed, spanning -126 to +129.
// RL13: Bit-test always copies the tested bit into carry.
// RL14: Bit set and clear: 3-bit index, data address, two bytes, four cycles.
// RL15: Bit operations reach any bit in the whole data space.
// RL16: Control ops: one byte, two cycles; only interrupt return sets flags.
// RL17: With watchdog selected, the stop instruction behaves as wait.
// RL18: Jump and call use 12-bit absolute address; two bytes, four cycles.
// RL19: Short branch opcode has a direction bit and a 4-bit magnitude.
// RL20: Opcode bit 4 picks the pointer register for indirect forms.
// RL21: Pointers and short registers live at data locations 80h to 83h.
// RL22: Zero set on zero result; carry shows carry-out or borrow.
// RL23: Taken branch adds displacement to its address, else falls through.
`timescale 1ns/100ps
module mie_core
  import mie_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Program space
  output logic [11:0] pgm_addr,
  input wire logic [7:0] pgm_data,
  // Data space
  output logic [7:0] data_raddr,
  input wire logic [7:0] data_rdata,
  output logic [7:0] data_waddr,
  output logic [7:0] data_wdata,
  output logic data_we,
  // Power modes
  input wire logic wdog_sel,
  input wire logic wake,
  output logic wait_mode,
  output logic stop_mode,
  // Status
  output logic [11:0] pc,
  output logic [7:0] acc,
  output logic zero_flag,
  output logic carry_flag,
  output logic instr_done
);

  mie_state_type state_reg, state_next;
  logic [2:0] cyc_reg, cyc_next, sp_reg, sp_next, bit_idx, exec_cyc, push_idx;
  logic [7:0] op_reg, op_next, b2_reg, b2_next, b3_reg, b3_next;
  logic [7:0] ptr_reg, ptr_next, acc_reg, acc_next, oaddr;
  logic [7:0] waddr_reg, waddr_next, wdata_reg, wdata_next;
  logic [7:0] alu_a, alu_b, alu_res;
  logic [11:0] pc_reg, pc_next, rel_target;
  logic [13:0] stack_mem [0:5];
  logic [13:0] stack_top;
  logic z_reg, z_next, c_reg, c_next, we_reg, we_next, done_reg, done_next;
  logic push_en, alu_z, alu_c, src_ind, src_short, src_imm, a_mem;
  logic wr_acc, wr_mem, upd_z, upd_c, exec_now, last_cyc, bit_val, rel_cond;
  logic [1:0] len;
  logic [2:0] ncyc;
  mie_kind_type kind;
  mie_alu_func_type alu_f;

  // ==========================================================================
  // Decode
  // ==========================================================================
  // Classifies the held opcode into kind, length, cycles and operand source.
  always_comb begin
    kind = K_NOP;
    len = LEN_1;
    ncyc = CYC_ALU;
    alu_f = ALU_PASS;
    src_ind = 1'b0;
    src_short = 1'b0;
    src_imm = 1'b0;
    a_mem = 1'b0;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    if (!op_reg[0]) begin
      kind = K_REL; // RL9
      ncyc = CYC_SHORT; // RL9
    end else begin
      case (op_reg[2:0])
        CLS_JUMP: begin
          kind = op_reg[3] ? K_JUMP : K_CALL; // RL18
          len = LEN_2; // RL18
        end
        CLS_BIT: begin
          if (op_reg[3]) begin
            kind = K_BIT; // RL14
            len = LEN_2; // RL14
          end else begin
            kind = K_BTEST;
            len = LEN_3; // RL11
            ncyc = CYC_BTEST; // RL11
          end
        end
        CLS_ALU: begin
          kind = K_ALU;
          alu_f = mie_alu_func_type'({1'b0, op_reg[7:5]});
          src_ind = !op_reg[3]; // RL20
          src_imm = op_reg[3] & op_reg[4]; // RL1
          len = src_ind ? LEN_1 : LEN_2; // RL4
          if (op_reg[7:5] <= 3'h3) begin
            wr_acc = (alu_f != ALU_CP); // RL1
            upd_z = 1'b1; // RL4
            upd_c = 1'b1; // RL4
          end else if (op_reg[7:5] <= 3'h5 && !src_imm) begin
            a_mem = 1'b1; // RL2
            wr_mem = 1'b1;
            upd_z = 1'b1; // RL5
          end else begin
            kind = K_NOP;
          end
        end
        default: begin
          case (op_reg[7:6])
            GRP_SHORT: begin
              kind = K_ALU;
              src_short = 1'b1; // RL21
              a_mem = 1'b1;
              wr_mem = 1'b1;
              upd_z = 1'b1; // RL5
              alu_f = op_reg[3] ? ALU_DEC : ALU_INC;
            end
            GRP_ACC: begin
              kind = K_ALU;
              wr_acc = 1'b1; // RL3
              upd_z = 1'b1; // RL3
              upd_c = 1'b1; // RL3
              case (op_reg[5:3])
                3'h0: alu_f = ALU_COM;
                3'h1: alu_f = ALU_RLC; // RL8
                3'h2: begin
                  alu_f = ALU_SLA;
                  len = LEN_2; // RL8
                end
                3'h3: begin
                  alu_f = ALU_CLR;
                  len = LEN_2; // RL7
                end
                3'h4, 3'h5: begin
                  alu_f = op_reg[3] ? ALU_DEC : ALU_INC;
                  len = LEN_2; // RL5
                  upd_c = 1'b0; // RL5
                end
                default: kind = K_NOP;
              endcase
            end
            GRP_DIR: begin
              kind = K_ALU;
              a_mem = 1'b1; // RL2
              wr_mem = 1'b1;
              if (op_reg[4]) begin
                alu_f = ALU_CLR;
                len = LEN_3; // RL6
              end else begin
                alu_f = op_reg[3] ? ALU_DEC : ALU_INC;
                len = LEN_2; // RL5
                upd_z = 1'b1; // RL5
              end
            end
            default: begin
              ncyc = CYC_SHORT; // RL16
              case (op_reg[5:3])
                CTL_RET: kind = K_RET;
                CTL_RETURN_FROM_INTERRUPT: kind = K_RETURN_FROM_INTERRUPT;
                CTL_STOP: kind = K_STOP;
                CTL_WAIT: kind = K_WAIT;
                default: kind = K_NOP;
              endcase
            end
          endcase
        end
      endcase
    end
    if (kind == K_NOP) begin
      ncyc = CYC_SHORT; // RL16
      len = LEN_1; // RL16
    end
  end

  // ==========================================================================
  // Operand paths
  // ==========================================================================
  // Picks the data-space address and ALU inputs for the held instruction.
  assign bit_idx = {op_reg[5], op_reg[6], op_reg[7]};
  assign oaddr = src_ind ? ptr_reg : // RL20
                 src_short ? (SHORT_BASE_ADDR | {6'h00, op_reg[5:4]}) :
                 b2_reg; // RL15
  assign alu_a = a_mem ? data_rdata : acc_reg; // RL1
  assign alu_b = src_imm ? b2_reg : data_rdata; // RL1
  assign bit_val = data_rdata[bit_idx];
  assign exec_cyc = (ncyc == CYC_SHORT) ? EXEC_SHORT : EXEC_LONG;
  assign exec_now = (state_reg == ST_RUN) && (cyc_reg == exec_cyc);
  assign last_cyc = (cyc_reg == ncyc - 3'h1);
  assign stack_top = stack_mem[(sp_reg == 3'h0) ? 3'h0 : sp_reg - 3'h1];
  assign push_idx = (sp_reg == STACK_FULL) ? STACK_LAST : sp_reg;
  // Direction bit 3 and magnitude bits 7:4 form the short displacement.
  assign rel_target = op_reg[3] ? pc_reg - {8'h00, op_reg[7:4]} : // RL19
                      pc_reg + {8'h00, op_reg[7:4]} + REL_FWD_OFS; // RL10
  // Condition pairs: not-zero, no-carry, zero, carry.
  assign rel_cond = op_reg[2] ? (op_reg[1] ? c_reg : z_reg) :
                    (op_reg[1] ? !c_reg : !z_reg); // RL9

  // Program fetch walks through the bytes of the instruction.
  assign pgm_addr = pc_reg + {9'h000, cyc_reg};
  // Cycle two reads the pointer selected by opcode bit 4.
  assign data_raddr = (cyc_reg == 3'h2) ?
                      (SHORT_BASE_ADDR | {7'h00, op_reg[4]}) : oaddr; // RL20

  mie_alu u_alu (
    .func(alu_f),
    .op_a(alu_a),
    .op_b(alu_b),
    .carry_in(c_reg),
    .result(alu_res),
    .zero_out(alu_z),
    .carry_out(alu_c)
  );

  // ==========================================================================
  // Sequencer and execution
  // ==========================================================================
  // Fetches bytes, executes at a fixed cycle and ends on the cycle count.
  always_comb begin
    state_next = state_reg;
    cyc_next = cyc_reg;
    op_next = op_reg;
    b2_next = b2_reg;
    b3_next = b3_reg;
    ptr_next = ptr_reg;
    pc_next = pc_reg;
    acc_next = acc_reg;
    z_next = z_reg;
    c_next = c_reg;
    sp_next = sp_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    we_next = 1'b0;
    done_next = 1'b0;
    push_en = 1'b0;
    unique case (state_reg)
      ST_RUN: begin
        unique case (cyc_reg)
          3'h0: op_next = pgm_data;
          3'h1: b2_next = pgm_data;
          3'h2: begin
            b3_next = pgm_data;
            ptr_next = data_rdata;
          end
          default: ;
        endcase
        if (exec_now) begin
          pc_next = pc_reg + {10'h000, len}; // RL23
          unique case (kind)
            K_REL: if (rel_cond) pc_next = rel_target; // RL23
            K_JUMP: pc_next = {op_reg[7:4], b2_reg}; // RL18
            K_CALL: begin
              push_en = 1'b1;
              pc_next = {op_reg[7:4], b2_reg}; // RL18
              if (sp_reg != STACK_FULL) sp_next = sp_reg + 3'h1;
            end
            K_RET, K_RETURN_FROM_INTERRUPT: begin
              pc_next = stack_top[11:0];
              if (sp_reg != 3'h0) sp_next = sp_reg - 3'h1;
              if (kind == K_RETURN_FROM_INTERRUPT) begin
                z_next = stack_top[13]; // RL16
                c_next = stack_top[12]; // RL16
              end
            end
            K_BTEST: begin
              c_next = bit_val; // RL13
              if (bit_val == op_reg[4]) begin
                pc_next = pc_reg + BTEST_OFS + {{4{b3_reg[7]}}, b3_reg}; // RL12
              end
            end
            K_BIT: begin
              waddr_next = b2_reg; // RL15
              wdata_next = data_rdata;
              wdata_next[bit_idx] = op_reg[4]; // RL14
              we_next = 1'b1;
            end
            K_ALU: begin
              if (wr_acc) acc_next = alu_res;
              if (wr_mem) begin
                waddr_next = oaddr; // RL2
                wdata_next = alu_res;
                we_next = 1'b1;
              end
              if (upd_z) z_next = alu_z; // RL22
              if (upd_c) c_next = alu_c; // RL22
            end
            K_STOP: state_next = wdog_sel ? ST_WAIT : ST_STOP; // RL17
            K_WAIT: state_next = ST_WAIT;
            K_NOP: ;
          endcase
        end
        if (last_cyc) begin
          cyc_next = 3'h0; // RL4
          done_next = 1'b1;
        end else begin
          cyc_next = cyc_reg + 3'h1;
        end
      end
      ST_WAIT, ST_STOP: if (wake) state_next = ST_RUN;
    endcase
  end

  // Registers all core state except the return stack.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg <= ST_RUN;
      cyc_reg <= 3'h0;
      op_reg <= 8'h00;
      b2_reg <= 8'h00;
      b3_reg <= 8'h00;
      ptr_reg <= 8'h00;
      pc_reg <= PC_RESET;
      acc_reg <= 8'h00;
      z_reg <= 1'b0;
      c_reg <= 1'b0;
      sp_reg <= 3'h0;
      waddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      we_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cyc_reg <= cyc_next;
      op_reg <= op_next;
      b2_reg <= b2_next;
      b3_reg <= b3_next;
      ptr_reg <= ptr_next;
      pc_reg <= pc_next;
      acc_reg <= acc_next;
      z_reg <= z_next;
      c_reg <= c_next;
      sp_reg <= sp_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      we_reg <= we_next;
      done_reg <= done_next;
    end
  end

  // Return stack holds flags and return address per level.
  always_ff @(posedge ref_clk) begin
    if (push_en) stack_mem[push_idx] <= {z_reg, c_reg, pc_reg + CALL_RET_OFS};
  end

  // Output assignments.
  assign data_waddr = waddr_reg;
  assign data_wdata = wdata_reg;
  assign data_we = we_reg;
  assign wait_mode = (state_reg == ST_WAIT);
  assign stop_mode = (state_reg == ST_STOP);
  assign pc = pc_reg;
  assign acc = acc_reg;
  assign zero_flag = z_reg;
  assign carry_flag = c_reg;
  assign instr_done = done_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_decoded(logic [2:0] cls);
    state_reg == ST_RUN && cyc_reg == 3'h1 && op_reg[2:0] == cls;
  endsequence

  property p_alu_cycles;
    s_decoded(CLS_ALU) ##0 kind == K_ALU |-> (!instr_done)[*3] ##1 instr_done;
  endproperty
  a_alu_cycles: assert property (p_alu_cycles) // RL4
    else $error("alu instruction not four cycles");

  property p_rel_cycles;
    state_reg == ST_RUN && cyc_reg == 3'h1 && !op_reg[0] |=> instr_done;
  endproperty
  a_rel_cycles: assert property (p_rel_cycles) // RL9
    else $error("short branch not two cycles");

  property p_btest_cycles;
    s_decoded(CLS_BIT) ##0 !op_reg[3] |-> (!instr_done)[*4] ##1 instr_done;
  endproperty
  a_btest_cycles: assert property (p_btest_cycles) // RL11
    else $error("bit test branch not five cycles");

  property p_btest_carry;
    exec_now && kind == K_BTEST
      |=> carry_flag == $past(bit_val) && $stable(z_reg);
  endproperty
  a_btest_carry: assert property (p_btest_carry) // RL13
    else $error("tested bit not copied to carry");

  property p_rel_target;
    exec_now && kind == K_REL |=> pc == ($past(rel_cond) ?
      ($past(op_reg[3]) ? $past(pc_reg) - {8'h00, $past(op_reg[7:4])} :
       $past(pc_reg) + {8'h00, $past(op_reg[7:4])} + 12'h001) :
      $past(pc_reg) + 12'h001);
  endproperty
  a_rel_target: assert property (p_rel_target) // RL10
    else $error("short branch target wrong");

  property p_incdec_carry;
    exec_now && kind == K_ALU && (alu_f == ALU_INC || alu_f == ALU_DEC)
      |=> $stable(carry_flag) && zero_flag == ($past(alu_res) == 8'h00);
  endproperty
  a_incdec_carry: assert property (p_incdec_carry) // RL5
    else $error("increment or decrement flags wrong");

  property p_stop_wdog;
    exec_now && kind == K_STOP && wdog_sel |=> wait_mode && !stop_mode;
  endproperty
  a_stop_wdog: assert property (p_stop_wdog) // RL17
    else $error("stop not replaced by wait");

  property p_bit_write;
    exec_now && kind == K_BIT |=> data_we && data_waddr == $past(b2_reg)
      && data_wdata[$past(bit_idx)] == $past(op_reg[4]) && $stable(c_reg);
  endproperty
  a_bit_write: assert property (p_bit_write) // RL14
    else $error("bit set or clear wrong");

  property p_jump;
    exec_now && kind == K_JUMP |=> pc == {$past(op_reg[7:4]), $past(b2_reg)};
  endproperty
  a_jump: assert property (p_jump) // RL18
    else $error("jump target wrong");

endmodule

//--- rtl/mie_pkg.sv
// Shared constants and types for the 8-bit instruction execute core.
// Assumes a core clock of 200 MHz and asynchronous-read memories outside.
package mie_pkg;

  // ==========================================================================
  // Data-space locations
  // ==========================================================================
  // Pointer registers sit at the base and the location above, short-direct registers at the base and the three locations above.
  localparam logic [7:0] SHORT_BASE_ADDR = 8'h80;

  // ==========================================================================
  // Lengths, cycle counts and offsets
  // ==========================================================================
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [2:0] CYC_SHORT = 3'h2;
  localparam logic [2:0] CYC_ALU = 3'h4;
  localparam logic [2:0] CYC_BTEST = 3'h5;
  localparam logic [2:0] EXEC_SHORT = 3'h1;
  localparam logic [2:0] EXEC_LONG = 3'h3;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [11:0] REL_FWD_OFS = 12'h001;
  localparam logic [11:0] BTEST_OFS = 12'h002;
  localparam logic [11:0] CALL_RET_OFS = 12'h002;
  localparam logic [2:0] STACK_LAST = 3'h5;
  localparam logic [2:0] STACK_FULL = 3'h6;

  // ==========================================================================
  // Opcode classes (bits 2:0, odd codes) and groups (bits 7:6)
  // ==========================================================================
  localparam logic [2:0] CLS_JUMP = 3'h1;
  localparam logic [2:0] CLS_BIT = 3'h3;
  localparam logic [2:0] CLS_ALU = 3'h7;
  localparam logic [1:0] GRP_SHORT = 2'h0;
  localparam logic [1:0] GRP_ACC = 2'h1;
  localparam logic [1:0] GRP_DIR = 2'h2;
  localparam logic [2:0] CTL_RET = 3'h1;
  localparam logic [2:0] CTL_RETURN_FROM_INTERRUPT = 3'h2;
  localparam logic [2:0] CTL_STOP = 3'h3;
  localparam logic [2:0] CTL_WAIT = 3'h4;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_AND = 4'h1, ALU_CP = 4'h2, ALU_SUB = 4'h3,
    ALU_INC = 4'h4, ALU_DEC = 4'h5, ALU_COM = 4'h6, ALU_RLC = 4'h7,
    ALU_SLA = 4'h8, ALU_CLR = 4'h9, ALU_PASS = 4'ha
  } mie_alu_func_type;

  typedef enum logic [3:0] {
    K_NOP = 4'h0, K_REL = 4'h1, K_JUMP = 4'h2, K_CALL = 4'h3,
    K_BTEST = 4'h4, K_BIT = 4'h5, K_ALU = 4'h6, K_RET = 4'h7,
    K_RETURN_FROM_INTERRUPT = 4'h8, K_STOP = 4'h9, K_WAIT = 4'ha
  } mie_kind_type;

  // Gray-coded along run, wait, stop.
  typedef enum logic [1:0] {
    ST_RUN = 2'b00, ST_WAIT = 2'b01, ST_STOP = 2'b11
  } mie_state_type;

endpackage

//--- verification/test_mie_core.sv
// Self-checking bench for the instruction execute core.
// Assumes the core reads program and data memory combinationally; the
// bench models both memories and steps the core one instruction at a time.
`timescale 1ns/100ps
module test_mie_core
  import mie_pkg::*;
;
  // ==========================================================================
  // Signals, memories and counters
  // ==========================================================================
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wdog_sel = 1'b0;
  logic wake = 1'b0;
  logic [11:0] pgm_addr, pc;
  logic [7:0] pgm_data, data_raddr, data_rdata, data_waddr, data_wdata, acc;
  logic data_we, wait_mode, stop_mode, zero_flag, carry_flag, instr_done;
  logic [7:0] rom [4096];
  logic [7:0] dmem [256];
  int err_total = 0;
  int compares = 0;
  int cycles = 0;

  // The clock toggles every half period of 2.5 ns.
  always #2.5 ref_clk = ~ref_clk;

  // Both memories answer in the same cycle as their address.
  assign pgm_data = rom[pgm_addr];
  assign data_rdata = dmem[data_raddr];

  mie_core i_mie_core (
    .ref_clk(ref_clk), .reset_n(reset_n), .pgm_addr(pgm_addr),
    .pgm_data(pgm_data), .data_raddr(data_raddr), .data_rdata(data_rdata),
    .data_waddr(data_waddr), .data_wdata(data_wdata), .data_we(data_we),
    .wdog_sel(wdog_sel), .wake(wake), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .pc(pc), .acc(acc), .zero_flag(zero_flag),
    .carry_flag(carry_flag), .instr_done(instr_done));

  // Writes land at the edge that samples the strobe; a hang ends the run.
  always @(posedge ref_clk) begin
    if (data_we === 1'b1) begin
      dmem[data_waddr] <= data_wdata;
    end
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_total++;
      end_of_test();
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [11:0] exp,
                     input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Places an instruction of n bytes, first byte highest, into program space.
  task automatic ld(input logic [11:0] a, input int n, input logic [23:0] b);
    for (int i = 0; i < n; i++) begin
      rom[a + i] = b[8 * (n - 1 - i) +: 8];
    end
  endtask

  // Holds reset for eight edges and checks the cleared state.
  task automatic rst();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    chk("reset pc", 12'h000, pc);
    chk("reset acc", 12'h000, {4'h0, acc});
    chk("reset flags", 12'h000, {10'h000, zero_flag, carry_flag});
    chk("reset modes", 12'h000, {9'h000, stop_mode, wait_mode, instr_done});
  endtask

  // Loads one instruction, waits for its completion and checks the results;
  // a cycle count of zero skips the timing check.
  task automatic ins(input logic [11:0] a, input int n, input logic [23:0] b,
      input int cyc, input logic [11:0] epc, input logic [7:0] eacc,
      input logic ez, input logic ec);
    int k;
    ld(a, n, b);
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (instr_done !== 1'b1 && k < 40);
    chk("done", 12'h001, {11'h000, instr_done});
    if (cyc != 0) begin
      chk("cycles", cyc[11:0], k[11:0]);
    end
    chk("pc", epc, pc);
    chk("acc", {4'h0, eacc}, {4'h0, acc});
    chk("zero", {11'h000, ez}, {11'h000, zero_flag});
    chk("carry", {11'h000, ec}, {11'h000, carry_flag});
  endtask

  // Checks the power mode, places the next opcode and wakes the core.
  task automatic nap(input logic es, input logic ew, input logic [11:0] a,
      input logic [7:0] b);
    @(posedge ref_clk);
    #1;
    chk("stop_mode", {11'h000, es}, {11'h000, stop_mode});
    chk("wait_mode", {11'h000, ew}, {11'h000, wait_mode});
    ld(a, 1, {16'h0000, b});
    @(posedge ref_clk);
    wake <= 1'b1;
    @(posedge ref_clk);
    wake <= 1'b0;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Accumulator arithmetic, short branches, jump, power modes, call, return.
  task automatic run_alu();
    ld(12'h000, 2, 24'h1ff0);
    rst();
    ins(12'h000, 2, 24'h1ff0, 0, 12'h002, 8'hf0, 1'b0, 1'b0);
    ins(12'h002, 2, 24'h1f20, 4, 12'h004, 8'h10, 1'b0, 1'b1);
    ins(12'h004, 1, 24'h36, 2, 12'h008, 8'h10, 1'b0, 1'b1);
    ins(12'h008, 2, 24'h5f10, 4, 12'h00a, 8'h10, 1'b1, 1'b0);
    ins(12'h00a, 2, 24'h7f11, 4, 12'h00c, 8'hff, 1'b0, 1'b1);
    ins(12'h00c, 1, 24'h45, 4, 12'h00d, 8'h00, 1'b1, 1'b1);
    ins(12'h00d, 2, 24'h5d00, 4, 12'h00f, 8'h00, 1'b1, 1'b0);
    ins(12'h00f, 2, 24'h1f81, 4, 12'h011, 8'h81, 1'b0, 1'b0);
    ins(12'h011, 2, 24'h5500, 4, 12'h013, 8'h02, 1'b0, 1'b1);
    ins(12'h013, 1, 24'h4d, 4, 12'h014, 8'h05, 1'b0, 1'b0);
    ins(12'h014, 2, 24'h3f04, 4, 12'h016, 8'h04, 1'b0, 1'b0);
    ins(12'h016, 1, 24'h54, 2, 12'h017, 8'h04, 1'b0, 1'b0);
    ins(12'h017, 1, 24'hf2, 2, 12'h027, 8'h04, 1'b0, 1'b0);
    ins(12'h027, 2, 24'h1950, 4, 12'h150, 8'h04, 1'b0, 1'b0);
    ins(12'h150, 1, 24'hf8, 2, 12'h141, 8'h04, 1'b0, 1'b0);
    ins(12'h141, 1, 24'hdd, 2, 12'h142, 8'h04, 1'b0, 1'b0);
    nap(1'b1, 1'b0, 12'h142, 8'hdd);
    wdog_sel <= 1'b1;
    ins(12'h142, 1, 24'hdd, 0, 12'h143, 8'h04, 1'b0, 1'b0);
    nap(1'b0, 1'b1, 12'h143, 8'h21);
    ins(12'h143, 2, 24'h2100, 0, 12'h200, 8'h04, 1'b0, 1'b0);
    ins(12'h200, 2, 24'h1ffc, 4, 12'h202, 8'h00, 1'b1, 1'b1);
    ins(12'h202, 1, 24'hd5, 2, 12'h145, 8'h00, 1'b0, 1'b0);
  endtask

  // Data-space operands, pointers, bit operations and bit-test branches.
  task automatic run_data();
    dmem[8'h80] = 8'h30;
    dmem[8'h81] = 8'h31;
    dmem[8'h30] = 8'h05;
    dmem[8'h31] = 8'hfb;
    dmem[8'h40] = 8'h81;
    dmem[8'h83] = 8'h01;
    ld(12'h000, 1, 24'h07);
    rst();
    ins(12'h000, 1, 24'h07, 0, 12'h001, 8'h05, 1'b0, 1'b0);
    ins(12'h001, 1, 24'h17, 4, 12'h002, 8'h00, 1'b1, 1'b1);
    ins(12'h002, 1, 24'h87, 4, 12'h003, 8'h00, 1'b0, 1'b1);
    ins(12'h003, 2, 24'h0f40, 4, 12'h005, 8'h81, 1'b0, 1'b0);
    ins(12'h005, 2, 24'h8d40, 4, 12'h007, 8'h81, 1'b0, 1'b0);
    ins(12'h007, 1, 24'h3d, 4, 12'h008, 8'h81, 1'b1, 1'b0);
    ins(12'h008, 3, 24'h9540aa, 4, 12'h00b, 8'h81, 1'b1, 1'b0);
    ins(12'h00b, 2, 24'hfb40, 4, 12'h00d, 8'h81, 1'b1, 1'b0);
    ins(12'h00d, 3, 24'hf3407f, 5, 12'h08e, 8'h81, 1'b1, 1'b1);
    ins(12'h08e, 3, 24'h034080, 5, 12'h010, 8'h81, 1'b1, 1'b0);
    ins(12'h010, 3, 24'h134005, 5, 12'h013, 8'h81, 1'b1, 1'b0);
    chk("mem 30", 12'h006, {4'h0, dmem[8'h30]});
    chk("mem 40", 12'h080, {4'h0, dmem[8'h40]});
    chk("mem 83", 12'h000, {4'h0, dmem[8'h83]});
    ins(12'h013, 2, 24'h6500, 4, 12'h015, 8'h82, 1'b0, 1'b0);
    ins(12'h015, 2, 24'heb40, 4, 12'h017, 8'h82, 1'b0, 1'b0);
    ins(12'h017, 2, 24'h1130, 4, 12'h130, 8'h82, 1'b0, 1'b0);
    ins(12'h130, 2, 24'h5f82, 4, 12'h132, 8'h82, 1'b1, 1'b0);
    ins(12'h132, 1, 24'hcd, 2, 12'h019, 8'h82, 1'b1, 1'b0);
    ins(12'h019, 1, 24'he5, 2, 12'h01a, 8'h82, 1'b1, 1'b0);
    nap(1'b0, 1'b1, 12'h01a, 8'hc5);
    ins(12'h01a, 1, 24'hc5, 2, 12'h01b, 8'h82, 1'b1, 1'b0);
    chk("mem 40 clr", 12'h000, {4'h0, dmem[8'h40]});
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  // Fills memories, runs every scenario and closes the run.
  initial begin
    for (int i = 0; i < 4096; i++) begin
      rom[i] = 8'hc5;
    end
    for (int i = 0; i < 256; i++) begin
      dmem[i] = 8'h00;
    end
    run_alu();
    run_data();
    end_of_test();
  end
endmodule
